// File: dv/flash_self_programming_tb_top.sv
// Testbench for the sequencer: APB master, flash model, directed scenarios.
// Assumes OP_CYCLES of 20 and a 10 MHz pclk.
`timescale 1ns/100ps
module flash_self_programming_tb_top import fsp_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        fuse, eep, rv_ok, halt, rblk, irq;
    logic [14:0] rvec, rd_addr;
    logic [15:0] rdata, bdata;
    logic [5:0]  bidx, lock;
    logic [8:0]  page;
    fsp_op_t     op;
    int          bad_count, total_checks, cyc;

    fsp_top #(.OP_CYCLES(16'h0014)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .boot_reset_select_fuse(fuse), .eeprom_write_active_bit(eep),
        .reset_vector(rvec), .reset_vector_valid(rv_ok), .cpu_halt(halt),
        .rww_read_block(rblk), .spm_irq(irq), .flash_op(op), .flash_page(page),
        .flash_rd_addr(rd_addr), .flash_rdata(rdata), .buf_idx(bidx),
        .buf_data(bdata), .lock_bits(lock));
    fsp_flash_model mdl (.rd_addr(rd_addr), .rdata(rdata));

    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            $display("Error at %0t: timeout", $time);
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; answer taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic buf_chk(input logic [5:0] i, input logic [15:0] e);
        @(posedge pclk);
        bidx <= i;
        @(posedge pclk);
        @(negedge pclk);
        chk(bdata, e);
    endtask
    // Software keeps each word loaded once between clears
    task automatic load(input logic [15:0] p, input logic [15:0] d);
        apb(1, 8'h04, p);
        apb(1, 8'h08, d);
        apb(1, 8'h00, 32'h01);
        apb(1, 8'h0c, 32'h0);
    endtask
    // Arm, store, then follow the long operation to its end
    task automatic run_op(input logic [31:0] c, input fsp_op_t o, input logic h,
                          input logic b, input logic [8:0] pg);
        int n, t0;
        n = 0;
        apb(0, 8'h18, 32'h0);
        chk(rd[0], 0);
        apb(1, 8'h00, c);
        apb(1, 8'h0c, 32'h0);
        @(negedge pclk);
        t0 = cyc;
        @(negedge pclk);
        chk(op, o);
        chk(halt, h);
        chk(rblk, b);
        apb(1, 8'h04, 32'h0);
        if (o != FSP_OP_LOCK) chk(page, pg);
        // Pointer now in the concurrent region: reads refused while busy
        apb(0, 8'h10, 32'h0);
        chk(err, b);
        while (op !== FSP_OP_IDLE && n < 100) begin
            @(negedge pclk);
            n++;
        end
        chk(cyc - t0, 20);
        chk(halt, 0);
        chk(irq, c[7]);
        apb(0, 8'h00, 32'h0);
        chk(rd[0], 0);
        chk(rd[6], b);
    endtask
    task automatic end_sim();
        $display("Checks %0d, errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, eep, paddr, pwdata, bidx} = '0;
        {fuse, bad_count, total_checks, cyc} = {1'b1, 96'h0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(rvec, 15'h0000);
        chk(rv_ok, 1);
        chk(lock, 6'h3f);
        // Buffer filled before erase, words out of order
        load(16'he00a, 16'h1234);
        load(16'he004, 16'h5678);
        buf_chk(6'h05, 16'h1234);
        buf_chk(6'h02, 16'h5678);
        run_op(32'h83, FSP_OP_ERASE, 1, 1, 9'h1c0);
        apb(1, 8'h00, 32'h11);
        @(negedge pclk);
        chk(rblk, 0);
        buf_chk(6'h05, 16'hffff);
        // Page write to the concurrent region, buffer clears after
        load(16'h0806, 16'hbeef);
        apb(1, 8'h04, 32'h0800);
        run_op(32'h05, FSP_OP_WRITE, 0, 1, 9'h010);
        buf_chk(6'h03, 16'hffff);
        apb(1, 8'h00, 32'h11);
        apb(1, 8'h08, 32'hf5);
        run_op(32'h09, FSP_OP_LOCK, 0, 0, 9'h0);
        chk(lock, 6'h35);
        // Store too late after arming
        apb(1, 8'h04, 32'h0008);
        apb(1, 8'h00, 32'h01);
        repeat (3) @(posedge pclk);
        apb(1, 8'h0c, 32'h0);
        buf_chk(6'h04, 16'hffff);
        apb(1, 8'h00, 32'h03);
        repeat (3) @(posedge pclk);
        apb(1, 8'h0c, 32'h0);
        @(negedge pclk);
        chk(op, FSP_OP_IDLE);
        apb(0, 8'h00, 32'h0);
        chk(rd[4:0], 5'h00);
        apb(1, 8'h04, 32'h0003);
        apb(0, 8'h10, 32'h0);
        chk(rd[7:0], 8'h5a);
        apb(0, 8'h20, 32'h0);
        chk(err, 1);
        // EEPROM write discards the buffer and refuses programming
        load(16'h000e, 16'h4321);
        eep <= 1'b1;
        repeat (4) @(posedge pclk);
        buf_chk(6'h07, 16'hffff);
        apb(1, 8'h00, 32'h03);
        apb(0, 8'h00, 32'h0);
        chk(rd[0], 0);
        apb(0, 8'h14, 32'h0);
        chk(err, 1);
        eep <= 1'b0;
        // Second reset with the fuse programmed
        presetn <= 1'b0;
        fuse    <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(rvec, 15'h3800);
        chk(rv_ok, 1);
        end_sim();
    end
endmodule

// File: dv/fsp_flash_model.sv
// Flash array model: a fixed pattern word for every word address.
// Assumes the sequencer presents the read address in the pclk domain.
`timescale 1ns/100ps
module fsp_flash_model (
    // Read port
    input  wire logic [14:0] rd_addr,
    output logic      [15:0] rdata
);
    // Address mixed with a pattern; the two bytes differ unless the low address byte equals the upper seven bits
    assign rdata = {1'b0, rd_addr} ^ 16'h5a5a;
endmodule

// File: rtl/fsp_defs.svh
// Constants for the flash self-programming sequencer: offsets, fields, codes, timing.
// Assumes a 10 MHz pclk and a 32-bit APB register bus.
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// Clock and programming time
`define FSP_CLK_KHZ        10000
`define FSP_OP_MIN_US      3700
`define FSP_OP_MAX_US      4500
`define FSP_OP_MIN_CYC     ((`FSP_OP_MIN_US * `FSP_CLK_KHZ + 999) / 1000)
`define FSP_OP_MAX_CYC     ((`FSP_OP_MAX_US * `FSP_CLK_KHZ) / 1000)
`define FSP_TMR_W          16
`define FSP_ARM_CYC        3'h4

// APB register byte offsets
`define FSP_OFS_CTRL       8'h00
`define FSP_OFS_PTR        8'h04
`define FSP_OFS_DATA       8'h08
`define FSP_OFS_EXEC       8'h0c
`define FSP_OFS_READ       8'h10
`define FSP_OFS_LOCK       8'h14
`define FSP_OFS_STAT       8'h18

// Control register bit positions
`define FSP_CB_EN          0
`define FSP_CB_IE          7

// Command codes in control bits 6..0 (bit 7 is the interrupt enable)
`define FSP_CMD_LOAD       7'h01
`define FSP_CMD_ERASE      7'h03
`define FSP_CMD_WRITE      7'h05
`define FSP_CMD_LOCK       7'h09
`define FSP_CMD_REEN       7'h11

// Pointer fields and memory layout
`define FSP_WORD_LSB       1
`define FSP_WORD_W         6
`define FSP_PAGE_LSB       7
`define FSP_PAGE_W         9
`define FSP_PAGE_WORDS     64
`define FSP_NO_READ_WHILE_WRITE_REGION_PAGE      9'h1c0
`define FSP_APP_VECTOR     15'h0000
`define FSP_BOOT_VECTOR    15'h3800
`define FSP_LOCK_RST       6'h3f
`define FSP_BUF_ERASED     16'hffff

`endif

// File: rtl/fsp_pkg.sv
// Types shared by the flash self-programming sequencer.
// Assumes the constants header is compiled alongside.
package fsp_pkg;
    // Long operation under way on the flash array
    typedef enum logic [1:0] {
        FSP_OP_IDLE,
        FSP_OP_ERASE,
        FSP_OP_WRITE,
        FSP_OP_LOCK
    } fsp_op_t;
endpackage

// File: rtl/fsp_timer.sv
// Programming timer: one start pulse, a done pulse after a fixed cycle count.
// Assumes start only arrives while idle.
`timescale 1ns/100ps
`include "fsp_defs.svh"
module fsp_timer #(
    parameter logic [`FSP_TMR_W-1:0] CYCLES = `FSP_TMR_W'(`FSP_OP_MIN_CYC)
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic start,
    output logic      done
);
    logic [`FSP_TMR_W-1:0] cnt_ff;

    // Count down from the start; done fires as the count reaches one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (start) begin
            cnt_ff <= CYCLES;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - `FSP_TMR_W'(1);
        end
    end

    assign done = (cnt_ff == `FSP_TMR_W'(1));
endmodule

// File: rtl/fsp_top.sv
// Flash self-programming sequencer: APB registers, page buffer, erase/write/lock timing.
// Assumes pclk at 10 MHz, fuse and EEPROM status from outside the clock domain,
// and a flash array that returns its data word combinationally, in the same cycle as the address.
//
// Summary of operation
// - Reset vector is 0x0000 with fuse at 1, boot loader vector with fuse at 0.
// - Fuse is an input only; nothing inside can change it.
// - Pointer upper bits pick the page, lower bits the word in the page.
// - Target page is latched at operation start; later pointer writes do not matter.
// - Lock-bit setting ignores the pointer entirely.
// - Program-memory reads use pointer bit 0 as byte select.
// - Buffer words may be loaded in any order.
// - Code x0000011 then store within four cycles erases the pointer's page.
// - Erase or write of the no-read-while-write region halts the core; others do not.
// - Code 00000001 then store within four cycles loads the data pair into a word.
// - Buffer clears after page write, on re-enable write, and on reset.
// - An EEPROM write during page loading discards the loaded buffer.
// - Code x0000101 then store within four cycles writes the buffer to the page.
// - Enabled interrupt stays high while the enable bit reads cleared.
// - Erase or write blocks region reads and holds the busy flag.
// - Writing the re-enable code clears the region-busy flag.
// - Code x0001001 then store programs lock bits whose data bits 5..0 are zero.
// - Lock programming never halts the core nor blocks reads.
// - During an EEPROM write, programming and lock reads are refused.
// - Without a store within four cycles, command and enable bits auto-clear.
// - Erase, write and lock operations each last between 3.7 ms and 4.5 ms.
// - Lock bits read zero when programmed and one when unprogrammed.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "fsp_defs.svh"
module fsp_top
    import fsp_pkg::*;
#(
    parameter logic [`FSP_TMR_W-1:0] OP_CYCLES = `FSP_TMR_W'(`FSP_OP_MIN_CYC)
) (
    // APB slave
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // Pins from outside the clock domain
    input  wire logic                   boot_reset_select_fuse,
    input  wire logic                   eeprom_write_active_bit,
    // Core side
    output logic [14:0]                 reset_vector,
    output logic                        reset_vector_valid,
    output logic                        cpu_halt,
    output logic                        rww_read_block,
    output logic                        spm_irq,
    // Flash array side
    output fsp_op_t                     flash_op,
    output logic [`FSP_PAGE_W-1:0]      flash_page,
    output logic [14:0]                 flash_rd_addr,
    input  wire logic [15:0]            flash_rdata,
    input  wire logic [`FSP_WORD_W-1:0] buf_idx,
    output logic [15:0]                 buf_data,
    output logic [5:0]                  lock_bits
);
    // Register decode, used by every register access
    function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
    endfunction

    // Page lies in the no-read-while-write region
    function automatic logic in_no_read_while_write_region(input logic [`FSP_PAGE_W-1:0] pg);
        in_no_read_while_write_region = (pg >= `FSP_NO_READ_WHILE_WRITE_REGION_PAGE);
    endfunction

    logic                   pready_ff, pslverr_ff;
    logic [31:0]            prdata_ff;
    logic                   fuse_m_ff, fuse_s_ff, eep_m_ff, eep_s_ff, eep_d_ff;
    logic [1:0]             boot_stage_ff;
    logic [14:0]            vector_ff;
    logic                   vector_valid_ff;
    logic [7:0]             ctrl_ff, nxt_ctrl;
    logic [2:0]             arm_cnt_ff;
    logic [15:0]            ptr_ff, data_ff;
    fsp_op_t                op_ff;
    logic [`FSP_PAGE_W-1:0] page_ff;
    logic                   halt_ff, rww_busy_ff, irq_ff;
    logic [5:0]             lock_ff, lock_req_ff;
    logic [14:0]            rd_addr_ff;
    logic [15:0]            buf_out_ff;
    logic [15:0]            buf_mem_ff [`FSP_PAGE_WORDS];
    logic [`FSP_PAGE_WORDS-1:0] buf_vld_ff;
    logic [31:0]            nxt_prdata;
    logic                   nxt_slverr;
    logic                   apb_done, wr_en, ctrl_wr, ctrl_ok, exec_wr, exec_go;
    logic                   start_erase, start_write, start_lock, start_load, start_op;
    logic                   reen_do, buf_clr, eep_rise, tmr_done, arm_timeout;
    logic [`FSP_PAGE_W-1:0] ptr_page;
    logic [`FSP_WORD_W-1:0] ptr_word;

    // Transfer completes at the edge that sees pready with psel and penable
    assign apb_done = psel & penable & pready_ff;
    assign wr_en    = apb_done & pwrite;
    assign ctrl_wr  = wr_en & hit(paddr, `FSP_OFS_CTRL);
    assign exec_wr  = wr_en & hit(paddr, `FSP_OFS_EXEC);
    // Control writes are dropped while EEPROM is busy or an operation runs
    assign ctrl_ok  = ctrl_wr & ~eep_s_ff & (op_ff == FSP_OP_IDLE);
    assign reen_do  = ctrl_ok & (pwdata[6:0] == `FSP_CMD_REEN);

    // Pointer fields: page in the upper bits, word in the lower
    assign ptr_page = ptr_ff[`FSP_PAGE_LSB +: `FSP_PAGE_W];
    assign ptr_word = ptr_ff[`FSP_WORD_LSB +: `FSP_WORD_W];

    // Store instruction counts only inside the arm window
    assign exec_go     = exec_wr & (arm_cnt_ff != 3'h0) & ctrl_ff[`FSP_CB_EN] & ~eep_s_ff;
    assign start_load  = exec_go & (ctrl_ff[6:0] == `FSP_CMD_LOAD);
    assign start_erase = exec_go & (ctrl_ff[6:0] == `FSP_CMD_ERASE);
    assign start_write = exec_go & (ctrl_ff[6:0] == `FSP_CMD_WRITE);
    assign start_lock  = exec_go & (ctrl_ff[6:0] == `FSP_CMD_LOCK);
    assign start_op    = start_erase | start_write | start_lock;
    assign arm_timeout = (arm_cnt_ff == 3'h1) & ~exec_go;
    assign eep_rise    = eep_s_ff & ~eep_d_ff;
    assign buf_clr     = reen_do | (tmr_done & (op_ff == FSP_OP_WRITE)) | eep_rise;

    // Operation timer shared by erase, write and lock programming
    fsp_timer #(.CYCLES(OP_CYCLES)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start_op),
        .done    (tmr_done)
    );

    // Pin synchronisers, plus a delayed copy for EEPROM edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_m_ff <= 1'b1;
            fuse_s_ff <= 1'b1;
            eep_m_ff  <= 1'b0;
            eep_s_ff  <= 1'b0;
            eep_d_ff  <= 1'b0;
        end else begin
            fuse_m_ff <= boot_reset_select_fuse;
            fuse_s_ff <= fuse_m_ff;
            eep_m_ff  <= eeprom_write_active_bit;
            eep_s_ff  <= eep_m_ff;
            eep_d_ff  <= eep_s_ff;
        end
    end

    // Reset vector chosen from the fuse once the synchroniser has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_stage_ff   <= 2'h0;
            vector_ff       <= `FSP_APP_VECTOR;
            vector_valid_ff <= 1'b0;
        end else if (boot_stage_ff != 2'h3) begin
            boot_stage_ff <= boot_stage_ff + 2'h1;
        end else if (!vector_valid_ff) begin
            // The fuse is only read, never written from here
            vector_ff       <= fuse_s_ff ? `FSP_APP_VECTOR : `FSP_BOOT_VECTOR;
            vector_valid_ff <= 1'b1;
        end
    end

    // Control register next value
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ctrl_ok) begin
            nxt_ctrl = {pwdata[7], 2'b00, pwdata[4:0]};
            if (reen_do) begin
                nxt_ctrl[4:0] = 5'h00;
            end
        end else if (start_load || (exec_go && !start_op)) begin
            nxt_ctrl[4:0] = 5'h00;
        end else if (tmr_done) begin
            nxt_ctrl[4:0] = 5'h00;
        end else if (arm_timeout && op_ff == FSP_OP_IDLE) begin
            nxt_ctrl[4:0] = 5'h00;
        end
    end

    // Control register and interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 8'h00;
            irq_ff  <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            irq_ff  <= nxt_ctrl[`FSP_CB_IE] & ~nxt_ctrl[`FSP_CB_EN];
        end
    end

    // Arm window: four cycles from the control write to the store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_cnt_ff <= 3'h0;
        end else if (ctrl_ok && pwdata[`FSP_CB_EN] && !reen_do) begin
            arm_cnt_ff <= `FSP_ARM_CYC;
        end else if (exec_go) begin
            arm_cnt_ff <= 3'h0;
        end else if (arm_cnt_ff != 3'h0) begin
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
        end
    end

    // Pointer and data pair, written freely by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff  <= 16'h0000;
            data_ff <= 16'h0000;
        end else begin
            if (wr_en && hit(paddr, `FSP_OFS_PTR)) begin
                ptr_ff <= pwdata[15:0];
            end
            if (wr_en && hit(paddr, `FSP_OFS_DATA)) begin
                data_ff <= pwdata[15:0];
            end
        end
    end

    // Operation sequencer: page latched at start, idle again on timer done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ff   <= FSP_OP_IDLE;
            page_ff <= '0;
        end else begin
            unique case (op_ff)
                FSP_OP_IDLE: begin
                    if (start_erase) begin
                        op_ff   <= FSP_OP_ERASE;
                        page_ff <= ptr_page;
                    end else if (start_write) begin
                        op_ff   <= FSP_OP_WRITE;
                        page_ff <= ptr_page;
                    end else if (start_lock) begin
                        op_ff <= FSP_OP_LOCK;
                    end
                end
                FSP_OP_ERASE, FSP_OP_WRITE, FSP_OP_LOCK: begin
                    if (tmr_done) begin
                        op_ff <= FSP_OP_IDLE;
                    end
                end
            endcase
        end
    end

    // Core halt only for erase or write aimed at the no-read-while-write region
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_ff <= 1'b0;
        end else if ((start_erase || start_write) && in_no_read_while_write_region(ptr_page)) begin
            halt_ff <= 1'b1;
        end else if (tmr_done) begin
            halt_ff <= 1'b0;
        end
    end

    // Region-busy flag: set by erase or write, cleared by the re-enable code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rww_busy_ff <= 1'b0;
        end else if (start_erase || start_write) begin
            rww_busy_ff <= 1'b1;
        end else if (reen_do) begin
            rww_busy_ff <= 1'b0;
        end
    end

    // Lock bits: programmed where the low data register holds zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff     <= `FSP_LOCK_RST;
            lock_req_ff <= `FSP_LOCK_RST;
        end else if (start_lock) begin
            lock_req_ff <= data_ff[5:0];
        end else if (tmr_done && op_ff == FSP_OP_LOCK) begin
            lock_ff <= lock_ff & lock_req_ff;
        end
    end

    // Temporary page buffer, one word per generate slice, loaded in any order
    generate
        for (genvar gi = 0; gi < `FSP_PAGE_WORDS; gi++) begin : g_buf
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    buf_vld_ff[gi] <= 1'b0;
                    buf_mem_ff[gi] <= `FSP_BUF_ERASED;
                end else if (buf_clr) begin
                    buf_vld_ff[gi] <= 1'b0;
                    buf_mem_ff[gi] <= `FSP_BUF_ERASED;
                end else if (start_load && ptr_word == `FSP_WORD_W'(gi)) begin
                    buf_vld_ff[gi] <= 1'b1;
                    buf_mem_ff[gi] <= data_ff;
                end
            end
        end
    endgenerate

    // Flash-side read ports: buffer word and program-memory word address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_out_ff <= `FSP_BUF_ERASED;
            rd_addr_ff <= 15'h0000;
        end else begin
            buf_out_ff <= buf_mem_ff[buf_idx];
            rd_addr_ff <= ptr_ff[15:1];
        end
    end

    // APB read data and error decode
    always_comb begin
        nxt_prdata = 32'h00000000;
        nxt_slverr = 1'b0;
        if (hit(paddr, `FSP_OFS_CTRL)) begin
            nxt_prdata[7:0] = {ctrl_ff[7], rww_busy_ff, 1'b0, ctrl_ff[4:0]};
        end else if (hit(paddr, `FSP_OFS_PTR)) begin
            nxt_prdata[15:0] = ptr_ff;
        end else if (hit(paddr, `FSP_OFS_DATA)) begin
            nxt_prdata[15:0] = data_ff;
        end else if (hit(paddr, `FSP_OFS_EXEC)) begin
            nxt_prdata = 32'h00000000;
        end else if (hit(paddr, `FSP_OFS_READ)) begin
            // Byte select from pointer bit 0; blocked region reads fail
            nxt_prdata[7:0] = ptr_ff[0] ? flash_rdata[15:8] : flash_rdata[7:0];
            nxt_slverr      = rww_busy_ff & ~in_no_read_while_write_region(ptr_page);
        end else if (hit(paddr, `FSP_OFS_LOCK)) begin
            nxt_prdata[7:0] = {2'b11, lock_ff};
            nxt_slverr      = eep_s_ff;
        end else if (hit(paddr, `FSP_OFS_STAT)) begin
            nxt_prdata[3:0] = {vector_valid_ff, halt_ff, (op_ff != FSP_OP_IDLE), eep_s_ff};
        end else begin
            nxt_slverr = 1'b1;
        end
        if (pwrite) begin
            nxt_prdata = 32'h00000000;
        end
    end

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else if (psel && penable && !pready_ff) begin
            pready_ff  <= 1'b1;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_slverr | (pwrite & (hit(paddr, `FSP_OFS_READ)
                          | hit(paddr, `FSP_OFS_LOCK) | hit(paddr, `FSP_OFS_STAT)));
        end else begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign pready             = pready_ff;
    assign prdata             = prdata_ff;
    assign pslverr            = pslverr_ff;
    assign reset_vector       = vector_ff;
    assign reset_vector_valid = vector_valid_ff;
    assign cpu_halt           = halt_ff;
    assign rww_read_block     = rww_busy_ff;
    assign spm_irq            = irq_ff;
    assign flash_op           = op_ff;
    assign flash_page         = page_ff;
    assign flash_rd_addr      = rd_addr_ff;
    assign buf_data           = buf_out_ff;
    assign lock_bits          = lock_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Arm then store: named steps of a command
    sequence s_arm_erase;
        ctrl_ok && pwdata[6:0] == `FSP_CMD_ERASE;
    endsequence
    sequence s_store;
        exec_wr && !eep_s_ff;
    endsequence

    chk_erase_window: assert property (s_arm_erase ##1 (!ctrl_wr && !exec_wr)[*4] |=>
        op_ff == FSP_OP_IDLE) else $error("erase started outside the window");
    chk_erase_start: assert property (s_arm_erase ##[1:4] s_store |=>
        op_ff == FSP_OP_ERASE && flash_page == $past(ptr_page)) else $error("erase not started");
    chk_arm_timeout: assert property (arm_timeout && op_ff == FSP_OP_IDLE && !ctrl_wr
        |=> ctrl_ff[4:0] == 5'h00) else $error("armed bits not cleared");
    chk_no_read_while_write_region_halt: assert property ((start_erase || start_write) && in_no_read_while_write_region(ptr_page)
        |=> cpu_halt until_with tmr_done) else $error("core not halted");
    chk_lock_nohalt: assert property (op_ff == FSP_OP_LOCK |-> !cpu_halt)
        else $error("lock programming halted core");
    chk_busy_held: assert property (op_ff == FSP_OP_ERASE || op_ff == FSP_OP_WRITE
        |-> rww_read_block) else $error("region busy flag dropped");
    chk_reen_clear: assert property (reen_do |=> !rww_read_block && buf_vld_ff == '0)
        else $error("re-enable did not clear");
    chk_eep_refuse: assert property (ctrl_wr && eep_s_ff && !tmr_done && arm_cnt_ff == 3'h0
        |=> $stable(ctrl_ff)) else $error("control written during EEPROM write");
    chk_done_clears: assert property (tmr_done |=> !ctrl_ff[`FSP_CB_EN] && op_ff == FSP_OP_IDLE)
        else $error("enable not cleared at completion");
    chk_irq_level: assert property (ctrl_ff[`FSP_CB_IE] && !ctrl_ff[`FSP_CB_EN] |-> spm_irq)
        else $error("interrupt not asserted");
    chk_page_latch: assert property (op_ff != FSP_OP_IDLE && $past(op_ff) != FSP_OP_IDLE
        |-> $stable(flash_page)) else $error("latched page moved");
endmodule
